// ---- rtl/fpsc_blink_if.sv ----
`timescale 1ns/1ps
// Display request from the supervisor to the blinker
interface fpsc_blink_if;
   logic [1:0] mode;
   logic ackStart;
   logic ackBusy;
   logic lamp;
   modport ctrl (output mode, output ackStart, input ackBusy, input lamp);
   modport blink (input mode, input ackStart, output ackBusy, output lamp);
endinterface // fpsc_blink_if

// ---- rtl/fpsc_blinker.sv ----
`timescale 1ns/1ps
module fpsc_blinker #(
   parameter int MS_CYC = fpsc_pkg::CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Display request from the supervisor
   fpsc_blink_if.blink bl
);
   import fpsc_pkg::*;

   logic [31:0] cycCnt_r;
   logic [9:0] msCnt_r;
   logic [2:0] ackLeft_r;
   logic lamp_r;
   logic msTick;
   logic inAck;
   logic [9:0] onMs;
   logic [9:0] periodMs;

   assign msTick = (cycCnt_r == 32'(MS_CYC - 1));
   assign inAck = (ackLeft_r != 3'h0);
   assign bl.ackBusy = inAck;
   assign bl.lamp = lamp_r;

   // Phase lengths per mode
   always_comb begin
      onMs = 10'(ACK_ON_MS);
      periodMs = 10'(ACK_ON_MS + ACK_OFF_MS);
      if (bl.mode == FPSC_SHOW_OVF) begin
         onMs = 10'(LONG_MS);
      end else if (bl.mode == FPSC_SHOW_ERR) begin
         onMs = 10'(SHORT_MS);
      end
      if (bl.mode != FPSC_SHOW_ACK) begin
         periodMs = 10'(LONG_MS + SHORT_MS);
      end
   end

   // Millisecond prescaler
   always_ff @(posedge clk) begin
      if (!rst_n || msTick) begin
         cycCnt_r <= 32'h0;
      end else begin
         cycCnt_r <= cycCnt_r + 32'h1;
      end
   end

   // Position inside the blink period; restarts on a new ack
   always_ff @(posedge clk) begin
      if (!rst_n || bl.ackStart) begin
         msCnt_r <= 10'h0;
      end else if (msTick) begin
         msCnt_r <= (msCnt_r == periodMs - 10'h1) ? 10'h0 : msCnt_r + 10'h1;
      end
   end

   // Ack flash counter: three flashes, counted at each period end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ackLeft_r <= 3'h0;
      end else if (bl.ackStart) begin
         ackLeft_r <= 3'(ACK_FLASHES);
      end else if (inAck && msTick && msCnt_r == periodMs - 10'h1) begin
         ackLeft_r <= ackLeft_r - 3'h1;
      end
   end

   // Lamp is lit in the first part of each period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lamp_r <= 1'b0;
      end else if (bl.mode == FPSC_SHOW_OFF || (bl.mode == FPSC_SHOW_ACK && !inAck)) begin
         lamp_r <= 1'b0;
      end else begin
         lamp_r <= (msCnt_r < onMs);
      end
   end

   chk_ack_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
      ackLeft_r <= 3'(ACK_FLASHES))
      else $error("ack flash count overrun");
endmodule // fpsc_blinker

// ---- rtl/fpsc_front_panel.sv ----
`timescale 1ns/1ps
module fpsc_front_panel #(
   parameter int HOLD_CYC = fpsc_pkg::HOLD_MS * fpsc_pkg::CYC_PER_MS,
   parameter int MS_CYC = fpsc_pkg::CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Operator and sensor status
   input wire logic identify_pushbutton,
   input wire logic cmdValid,
   input wire logic inputOverflow,
   input wire logic tcMode,
   input wire logic openTc,
   input wire logic internalError,
   // Address change from host
   input wire logic addrWrReq,
   input wire logic [7:0] addrWrData,
   // Measured value and ASCII read request
   input wire logic [15:0] measValue,
   input wire logic asciiReq,
   // Lamps
   output logic supply_indicator_lamp,
   output logic state_indicator_lamp,
   // Configuration
   output logic [7:0] moduleAddr,
   output logic [2:0] baudCode,
   output logic addrWrRefused,
   output logic restoreBackup,
   // Rate strobes and table index
   output logic procStrobe,
   output logic dacStrobe,
   output logic [fpsc_pkg::LIN_AW-1:0] linIndex,
   // ASCII value stream
   output logic asciiValid,
   output logic [7:0] asciiChar
);
   import fpsc_pkg::*;

   fpsc_blink_if bl();

   logic btnMeta_r, btnSync_r, btnPrev_r;
   logic [1:0] syncFill_r;
   logic [31:0] holdCnt_r;
   logic powerUp_r;
   logic unlock_r;
   logic [7:0] moduleAddr_r;
   logic [2:0] baudCode_r;
   logic refused_r;
   logic restore_r;
   logic [7:0] procCnt_r, dacCnt_r;
   logic procStb_r, dacStb_r;
   logic [LIN_AW-1:0] linIdx_r;
   logic [15:0] shiftVal_r;
   logic [2:0] charCnt_r;
   logic asciiValid_r;
   logic [7:0] asciiChar_r;
   logic showOvf;
   fpsc_show_t show;

   // Hex digit to ASCII, used for each nibble of the value
   function automatic logic [7:0] hexAscii(input logic [3:0] n);
      hexAscii = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   assign supply_indicator_lamp = rst_n | 1'b1;
   assign state_indicator_lamp = bl.lamp;
   assign moduleAddr = moduleAddr_r;
   assign baudCode = baudCode_r;
   assign addrWrRefused = refused_r;
   assign restoreBackup = restore_r;
   assign procStrobe = procStb_r;
   assign dacStrobe = dacStb_r;
   assign linIndex = linIdx_r;
   assign asciiValid = asciiValid_r;
   assign asciiChar = asciiChar_r;

   // Button synchroniser, the pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         btnMeta_r <= 1'b0;
         btnSync_r <= 1'b0;
         btnPrev_r <= 1'b0;
      end else begin
         btnMeta_r <= identify_pushbutton;
         btnSync_r <= btnMeta_r;
         btnPrev_r <= btnSync_r;
      end
   end

   // Synchroniser fill marker: the button level is trusted once both stages hold the pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncFill_r <= 2'h0;
      end else begin
         syncFill_r <= {syncFill_r[0], 1'b1};
      end
   end

   // Power-up hold window: a button not held after reset, or any release, shuts it for good,
   // so a long press later in operation can never wipe the setup
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         powerUp_r <= 1'b1;
         holdCnt_r <= 32'h0;
      end else if (powerUp_r) begin
         if (syncFill_r[1] && !btnSync_r) begin
            powerUp_r <= 1'b0;
         end else if (btnSync_r && holdCnt_r != 32'(HOLD_CYC)) begin
            holdCnt_r <= holdCnt_r + 32'h1;
         end
      end
   end

   // Factory reset pulse once the hold time is reached
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         restore_r <= 1'b0;
      end else begin
         restore_r <= powerUp_r && btnSync_r && holdCnt_r == 32'(HOLD_CYC - 1);
      end
   end

   // Address unlock: a press after power-up arms one address change
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         unlock_r <= 1'b0;
      end else if (!powerUp_r && btnSync_r && !btnPrev_r) begin
         unlock_r <= 1'b1; // a fresh press beats a write in the same cycle
      end else if (addrWrReq) begin
         unlock_r <= 1'b0;
      end
   end

   // Address and rate; factory reset wins over a host write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         moduleAddr_r <= DEF_ADDR;
         baudCode_r <= BAUD_CODE_9600;
         refused_r <= 1'b0;
      end else begin
         refused_r <= addrWrReq && !unlock_r;
         if (restore_r) begin
            moduleAddr_r <= DEF_ADDR;
            baudCode_r <= BAUD_CODE_9600;
         end else if (addrWrReq && unlock_r) begin
            moduleAddr_r <= addrWrData;
         end
      end
   end

   // Display priority: error, then overflow, then acknowledge
   assign showOvf = inputOverflow || (tcMode && openTc);
   always_comb begin
      if (internalError) begin
         show = FPSC_SHOW_ERR;
      end else if (showOvf) begin
         show = FPSC_SHOW_OVF;
      end else if (cmdValid || bl.ackBusy) begin
         show = FPSC_SHOW_ACK;
      end else begin
         show = FPSC_SHOW_OFF;
      end
   end
   assign bl.mode = show;
   assign bl.ackStart = cmdValid && !internalError && !showOvf;

   fpsc_blinker #(.MS_CYC(MS_CYC)) u_blinker (
      .clk(clk),
      .rst_n(rst_n),
      .bl(bl)
   );

   // Rate strobes for processing and output converter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         procCnt_r <= 8'h0;
         dacCnt_r <= 8'h0;
         procStb_r <= 1'b0;
         dacStb_r <= 1'b0;
      end else begin
         procStb_r <= (procCnt_r == 8'(PROC_DIV - 1));
         dacStb_r <= (dacCnt_r == 8'(DAC_DIV - 1));
         procCnt_r <= (procCnt_r == 8'(PROC_DIV - 1)) ? 8'h0 : procCnt_r + 8'h1;
         dacCnt_r <= (dacCnt_r == 8'(DAC_DIV - 1)) ? 8'h0 : dacCnt_r + 8'h1;
      end
   end

   // Table index from the top bits of each processed sample
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         linIdx_r <= '0;
      end else if (procStb_r) begin
         linIdx_r <= measValue[15 -: LIN_AW];
      end
   end

   // ASCII output: four hex digits then carriage return, one per cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         charCnt_r <= 3'h0;
         shiftVal_r <= 16'h0;
         asciiValid_r <= 1'b0;
         asciiChar_r <= 8'h00;
      end else if (charCnt_r == 3'h0) begin
         asciiValid_r <= 1'b0;
         if (asciiReq) begin
            shiftVal_r <= measValue;
            charCnt_r <= 3'h5;
         end
      end else begin
         asciiValid_r <= 1'b1;
         asciiChar_r <= (charCnt_r == 3'h1) ? 8'h0d : hexAscii(shiftVal_r[15:12]);
         shiftVal_r <= {shiftVal_r[11:0], 4'h0};
         charCnt_r <= charCnt_r - 3'h1;
      end
   end

   chk_refuse_locked: assert property (@(posedge clk) disable iff (!rst_n)
      addrWrReq && !unlock_r |=> refused_r && $stable(moduleAddr_r))
      else $error("locked address write not refused");
   chk_restore_defaults: assert property (@(posedge clk) disable iff (!rst_n)
      restore_r |=> moduleAddr_r == DEF_ADDR && baudCode_r == BAUD_CODE_9600)
      else $error("factory defaults not applied");
   chk_restore_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(restore_r) |-> $past(powerUp_r) && $past(btnSync_r))
      else $error("factory reset without power-up hold");
   chk_error_priority: assert property (@(posedge clk) disable iff (!rst_n)
      internalError |-> bl.mode == FPSC_SHOW_ERR)
      else $error("error not shown first");
   chk_ovf_mode: assert property (@(posedge clk) disable iff (!rst_n)
      !internalError && tcMode && openTc |-> bl.mode == FPSC_SHOW_OVF)
      else $error("open thermocouple not shown");
   chk_proc_rate: assert property (@(posedge clk) disable iff (!rst_n)
      procStb_r |=> !procStb_r [*8] ##72 procStb_r)
      else $error("processing strobe spacing wrong");
   chk_dac_rate: assert property (@(posedge clk) disable iff (!rst_n)
      dacStb_r |-> ##40 dacStb_r)
      else $error("converter strobe spacing wrong");
   chk_supply_lit: assert property (@(posedge clk) supply_indicator_lamp)
      else $error("supply lamp dark");
   chk_ascii_burst: assert property (@(posedge clk) disable iff (!rst_n)
      charCnt_r == 3'h0 && asciiReq |=> ##1 asciiValid_r [*5])
      else $error("ascii burst short");
   chk_ack_armed: assert property (@(posedge clk) disable iff (!rst_n)
      bl.ackStart |=> bl.ackBusy)
      else $error("acknowledge flashes not started");
   chk_idle_dark: assert property (@(posedge clk) disable iff (!rst_n)
      bl.mode == FPSC_SHOW_OFF |=> !state_indicator_lamp)
      else $error("status lamp lit while idle");
endmodule // fpsc_front_panel

// ---- rtl/fpsc_pkg.sv ----
package fpsc_pkg;
   // System clock
   localparam int CLK_HZ = 10_000_000;
   // Indicator timing in milliseconds
   localparam int LONG_MS = 800;
   localparam int SHORT_MS = 200;
   localparam int ACK_ON_MS = 200;
   localparam int ACK_OFF_MS = 200;
   localparam int ACK_FLASHES = 3;
   // Factory reset hold time in milliseconds
   localparam int HOLD_MS = 5000;
   // Cycles per millisecond, derived from the clock rate
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // Processing rates in samples per second
   localparam int PROC_SPS = 125_000;
   localparam int DAC_SPS = 250_000;
   localparam int PROC_DIV = CLK_HZ / PROC_SPS;
   localparam int DAC_DIV = CLK_HZ / DAC_SPS;
   // Linearisation table size
   localparam int LIN_POINTS = 512;
   localparam int LIN_AW = 9;
   // Factory defaults
   localparam logic [7:0] DEF_ADDR = 8'h00;
   localparam int DEF_BAUD = 9600;
   localparam logic [2:0] BAUD_CODE_9600 = 3'h0;
   // Indicator display modes
   typedef enum logic [1:0] {FPSC_SHOW_OFF, FPSC_SHOW_ACK, FPSC_SHOW_OVF, FPSC_SHOW_ERR} fpsc_show_t;
endpackage

// ---- test/fpsc_operator.sv ----
`timescale 1ns/1ps
// Operator button and serial host on the far side of the front panel
module fpsc_operator (
   // Bench commands
   input wire logic clk,
   input wire logic pressWant,
   // Device side
   output logic identify_pushbutton,
   input wire logic asciiValid,
   input wire logic [7:0] asciiChar,
   // Text seen by the host
   output logic [39:0] rxText,
   output int rxCount
);
   // Button follows the operator's hand; no bounce modelled, the sync stage sees clean edges
   assign identify_pushbutton = pressWant;
   // Host shifts in each character while the device marks it valid; a full burst refills the text
   always @(posedge clk) begin
      if (asciiValid === 1'b1) begin
         rxText <= {rxText[31:0], asciiChar};
         rxCount <= rxCount + 1;
      end
   end
endmodule // fpsc_operator

// ---- test/front_panel_status_control_test.sv ----
`timescale 1ns/1ps
module front_panel_status_control_test;
   import fpsc_pkg::*;
   // Short counts keep the run brief
   localparam int HOLD = 200;
   localparam int MSC = 5;
   logic clk, rst_n, pressWant, identBtn, cmdValid, inputOverflow, tcMode, openTc, internalError;
   logic addrWrReq, asciiReq, supplyLamp, stateLamp, addrWrRefused, restoreBackup;
   logic procStrobe, dacStrobe, asciiValid, p;
   logic [7:0] addrWrData, moduleAddr, asciiChar, a;
   logic [15:0] measValue;
   logic [2:0] baudCode;
   logic [LIN_AW-1:0] linIndex;
   logic [39:0] rxText;
   int rxCount, failures, samplesChecked, n, onC, offC;
   fpsc_front_panel #(.HOLD_CYC(HOLD), .MS_CYC(MSC)) i_dut (.clk(clk), .rst_n(rst_n),
      .identify_pushbutton(identBtn), .cmdValid(cmdValid), .inputOverflow(inputOverflow),
      .tcMode(tcMode), .openTc(openTc), .internalError(internalError), .addrWrReq(addrWrReq),
      .addrWrData(addrWrData), .measValue(measValue), .asciiReq(asciiReq),
      .supply_indicator_lamp(supplyLamp), .state_indicator_lamp(stateLamp),
      .moduleAddr(moduleAddr), .baudCode(baudCode), .addrWrRefused(addrWrRefused),
      .restoreBackup(restoreBackup), .procStrobe(procStrobe), .dacStrobe(dacStrobe),
      .linIndex(linIndex), .asciiValid(asciiValid), .asciiChar(asciiChar));
   fpsc_operator i_op (.clk(clk), .pressWant(pressWant), .identify_pushbutton(identBtn),
      .asciiValid(asciiValid), .asciiChar(asciiChar), .rxText(rxText), .rxCount(rxCount));
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks made %0d, mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   function automatic logic pick(input int k);
      logic [3:0] v;
      v = {dacStrobe, procStrobe, restoreBackup, stateLamp};
      return v[k];
   endfunction
   // Bounded wait for an output level; a hang ends the run as a mismatch
   task automatic wait_for(input int k, input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (pick(k) !== lvl) begin
         if (cyc == lim) begin
            failures++;
            end_of_test();
         end
         cyc++;
         @(negedge clk);
      end
   endtask
   // One full lamp period measured from a rising edge
   task automatic pattern(output int hi, output int lo);
      wait_for(0, 1'b0, 1000 * MSC + 10, hi);
      wait_for(0, 1'b1, 1000 * MSC + 10, hi);
      wait_for(0, 1'b0, 1000 * MSC + 10, hi);
      wait_for(0, 1'b1, 1000 * MSC + 10, lo);
   endtask
   function automatic logic [7:0] hexc(input logic [3:0] d);
      return (d < 4'ha) ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
   endfunction
   task automatic do_reset(input logic held);
      rst_n = 1'b0;
      pressWant = held;
      tick(10);
      rst_n = 1'b1;
   endtask
   // Locked writes must leave the address alone and raise one refusal
   task automatic addr_write(input logic [7:0] v, input logic ok, input logic [7:0] old);
      addrWrReq = 1'b1;
      addrWrData = v;
      n = 0;
      repeat (3) begin
         tick(1);
         addrWrReq = 1'b0;
         n += int'(addrWrRefused);
      end
      check(moduleAddr, ok ? v : old);
      check(n, !ok);
   endtask
   int cfg[4] = '{8, 6, 1, 9};
   int hiMs[4] = '{LONG_MS, LONG_MS, SHORT_MS, SHORT_MS};
   int loMs[4] = '{SHORT_MS, SHORT_MS, LONG_MS, LONG_MS};
   initial begin
      {rst_n, pressWant, cmdValid, inputOverflow, tcMode, openTc, internalError} = '0;
      {addrWrReq, asciiReq, addrWrData, measValue, failures, samplesChecked} = '0;
      void'($urandom(96200));
      tick(1);
      // Button held through power-up starts the factory restore
      do_reset(1'b1);
      check(supplyLamp, 1'b1);
      wait_for(1, 1'b1, HOLD + 20, n);
      check(n >= HOLD && n <= HOLD + 4, 1'b1);
      tick(1);
      check(restoreBackup, 1'b0);
      check({moduleAddr, baudCode}, {DEF_ADDR, BAUD_CODE_9600});
      // Pressed only after power-up, or released early: the window is shut, nothing restored
      for (int j = 0; j < 2; j++) begin
         do_reset(j == 1);
         tick(HOLD / 2);
         pressWant = (j == 0);
         n = 0;
         repeat (2 * HOLD) begin
            tick(1);
            n += int'(restoreBackup);
         end
         check(n, 0);
      end
      // Each press unlocks exactly one address change
      a = 8'h00;
      addr_write(8'h5a, 1'b0, a);
      for (int i = 0; i < 4; i++) begin
         pressWant = 1'b1;
         tick(6);
         pressWant = 1'b0;
         tick(2);
         addr_write(8'($urandom), 1'b1, a);
         a = moduleAddr;
         addr_write(~a, 1'b0, a);
      end
      // Strobe spacing, processing then converter
      for (int k = 2; k < 4; k++) begin
         wait_for(k, 1'b1, 100, n);
         tick(1);
         wait_for(k, 1'b1, 100, n);
         check(n + 1, (k == 2) ? PROC_DIV : DAC_DIV);
      end
      // Table index at both ends of the range and random inside
      for (int i = 0; i < 4; i++) begin
         measValue = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
         wait_for(2, 1'b1, 100, n);
         tick(3);
         check(linIndex, measValue[15:7]);
      end
      // ASCII readout, two requests, the second after the first burst has ended
      repeat (2) begin
         measValue = 16'($urandom);
         n = rxCount;
         asciiReq = 1'b1;
         tick(1);
         asciiReq = 1'b0;
         tick(10);
         check(rxCount - n, 5);
         check(rxText, {hexc(measValue[15:12]), hexc(measValue[11:8]), hexc(measValue[7:4]),
            hexc(measValue[3:0]), 8'h0d});
      end
      // Command acknowledge counts three flashes
      cmdValid = 1'b1;
      n = 0;
      p = 1'b0;
      repeat (1300 * MSC) begin
         tick(1);
         cmdValid = 1'b0;
         n += int'(stateLamp && !p);
         p = stateLamp;
      end
      check(n, ACK_FLASHES);
      // Condition patterns; an acknowledge raised at the same time must not show
      for (int i = 0; i < 4; i++) begin
         {inputOverflow, tcMode, openTc, internalError} = 4'(cfg[i]);
         cmdValid = 1'b1;
         tick(1);
         cmdValid = 1'b0;
         pattern(onC, offC);
         check({onC, offC}, {hiMs[i] * MSC, loMs[i] * MSC});
         {inputOverflow, tcMode, openTc, internalError} = 4'h0;
      end
      check(supplyLamp, 1'b1);
      end_of_test();
   end
endmodule // front_panel_status_control_test
